// [seepd_core.sv]
// seepd_core: command decoder for erase, deep power-down and signature.
// assumes: spi mode 0 host; array erase carried out by array logic on
// the erase_* outputs; protect bits come from the status store.
`timescale 1ns/1ns
module seepd_core (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic [1:0] block_protect,
	input wire logic ext_write_busy,
	input wire logic ext_write_done,
	output logic miso,
	output logic miso_oe_n,
	output logic write_in_progress,
	output logic write_enable_latch,
	output logic deep_powerdown,
	output logic active,
	output logic erase_start,
	output logic erase_chip,
	output logic [1:0] erase_sector
);
	import seepd_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef enum logic [2:0] {
		SEEPD_IDLE = 3'b000,
		SEEPD_OPC = 3'b001,
		SEEPD_ADDR = 3'b010,
		SEEPD_SIGOUT = 3'b011,
		SEEPD_SKIP = 3'b100
	} seepd_phase_e;

	typedef struct packed {
		seepd_phase_e phase;
		logic [5:0] bits;
		logic [7:0] opc;
		logic [SEEPD_ADDR_W-1:0] addr;
		logic [2:0] sbit;
		logic miso;
		logic miso_oe_n;
		logic latch;
		logic erasing;
		logic dpd;
		logic rel;
		logic act;
		seepd_erase_s er;
	} seepd_core_state_s;

	seepd_core_state_s st_r;
	seepd_core_state_s st_nxt;
	seepd_pins_s pins;
	seepd_evt_s evt;
	logic t_load;
	logic [23:0] t_count;
	logic t_busy;
	logic t_done;
	logic busy;
	logic [7:0] opc_in;

	assign pins = '{sclk: sclk, cs_n: cs_n, mosi: mosi};

	seepd_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pins(pins),
		.evt(evt)
	);

	seepd_timer u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.load(t_load),
		.count(t_count),
		.busy(t_busy),
		.done(t_done)
	);

	assign busy = (st_r.erasing & t_busy) | ext_write_busy;
	assign opc_in = {st_r.opc[6:0], evt.mosi};

	// ****************************************************************
	// decoder
	// ****************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.er.start = 1'b0;
		t_load = 1'b0;
		t_count = 24'(SEEPD_ERASE_CYC);
		if (t_done && st_r.erasing) begin
			st_nxt.erasing = 1'b0;
			st_nxt.latch = 1'b0;
		end
		if (t_done && st_r.rel) begin
			st_nxt.rel = 1'b0;
		end
		if (ext_write_done) begin
			st_nxt.latch = 1'b0;
		end
		if (evt.cs_fall) begin
			// the falling edge that activates the device also opens a frame
			st_nxt.act = 1'b1;
			st_nxt.phase = SEEPD_OPC;
			st_nxt.bits = 6'h00;
			st_nxt.sbit = 3'h0;
		end else if (evt.cs_rise) begin
			st_nxt.phase = SEEPD_IDLE;
			st_nxt.miso_oe_n = 1'b1;
			// signature opcode has moved on to the address phase at bit 8
			if ((st_r.phase == SEEPD_OPC || st_r.phase == SEEPD_ADDR)
				&& st_r.bits == SEEPD_OP_BITS) begin
				if (st_r.dpd) begin
					if (st_r.opc == SEEPD_OP_SIG) begin
						st_nxt.dpd = 1'b0;
						st_nxt.rel = 1'b1;
						t_load = 1'b1;
						t_count = 24'(SEEPD_REL_CYC);
					end
				end else if (!busy) begin
					case (st_r.opc)
						SEEPD_OP_WEN: st_nxt.latch = 1'b1;
						SEEPD_OP_WRDI: st_nxt.latch = 1'b0;
						SEEPD_OP_DPD: st_nxt.dpd = 1'b1;
						SEEPD_OP_CE: begin
							if (st_r.latch && block_protect == 2'h0) begin
								st_nxt.erasing = 1'b1;
								st_nxt.er = '{start: 1'b1, chip: 1'b1,
									sector: 2'h0};
								t_load = 1'b1;
							end
						end
						default: st_nxt.latch = st_r.latch;
					endcase
				end
			end else if (st_r.phase == SEEPD_ADDR && st_r.bits == SEEPD_ADR_BITS
				&& st_r.opc == SEEPD_OP_SE && !busy && !st_r.dpd) begin
				if (st_r.latch && !seepd_sect_prot(block_protect,
					st_r.addr[SEEPD_ADDR_W-1:SEEPD_SECT_LSB])) begin
					st_nxt.erasing = 1'b1;
					st_nxt.er = '{start: 1'b1, chip: 1'b0,
						sector: st_r.addr[SEEPD_ADDR_W-1:SEEPD_SECT_LSB]};
					t_load = 1'b1;
				end
			end else if (st_r.phase == SEEPD_SIGOUT && st_r.dpd) begin
				st_nxt.dpd = 1'b0;
				st_nxt.rel = 1'b1;
				t_load = 1'b1;
				t_count = 24'(SEEPD_REL_CYC);
			end
		end else if (evt.sel && evt.sclk_rise) begin
			case (st_r.phase)
				SEEPD_OPC: begin
					st_nxt.opc = opc_in;
					st_nxt.bits = st_r.bits + 6'h01;
					if (st_r.bits == SEEPD_OP_BITS - 6'h01) begin
						if (opc_in == SEEPD_OP_SE || opc_in == SEEPD_OP_SIG) begin
							if (st_r.dpd && opc_in != SEEPD_OP_SIG) begin
								st_nxt.phase = SEEPD_SKIP;
							end else if (!st_r.dpd && busy) begin
								st_nxt.phase = SEEPD_SKIP;
							end else begin
								st_nxt.phase = SEEPD_ADDR;
							end
						end
					end else if (st_r.bits >= SEEPD_OP_BITS) begin
						st_nxt.phase = SEEPD_SKIP;
					end
				end
				SEEPD_ADDR: begin
					st_nxt.addr = {st_r.addr[SEEPD_ADDR_W-2:0], evt.mosi};
					st_nxt.bits = st_r.bits + 6'h01;
					if (st_r.bits == SEEPD_ADR_BITS) begin
						st_nxt.phase = SEEPD_SKIP;
					end else if (st_r.bits == SEEPD_ADR_BITS - 6'h01
						&& st_r.opc == SEEPD_OP_SIG) begin
						st_nxt.phase = SEEPD_SIGOUT;
						st_nxt.sbit = 3'h0;
					end
				end
				default: st_nxt.bits = st_r.bits;
			endcase
		end else if (evt.sel && evt.sclk_fall && st_r.phase == SEEPD_SIGOUT) begin
			st_nxt.miso_oe_n = 1'b0;
			st_nxt.miso = SEEPD_SIGNATURE[3'h7 - st_r.sbit];
			st_nxt.sbit = st_r.sbit + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{phase: SEEPD_IDLE, bits: 6'h00, opc: 8'h00,
				addr: '0, sbit: 3'h0, miso: 1'b1, miso_oe_n: 1'b1,
				latch: 1'b0, erasing: 1'b0, dpd: 1'b0, rel: 1'b0, act: 1'b0,
				er: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign miso = st_r.miso;
	assign miso_oe_n = st_r.miso_oe_n;
	assign write_in_progress = st_r.erasing;
	assign write_enable_latch = st_r.latch;
	assign deep_powerdown = st_r.dpd | st_r.rel;
	assign active = st_r.act;
	assign erase_start = st_r.er.start;
	assign erase_chip = st_r.er.chip;
	assign erase_sector = st_r.er.sector;

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_ce_prot;
		@(posedge clk) disable iff (!rst_n)
		(erase_start && erase_chip) |-> $past(block_protect) == 2'h0;
	endproperty
	a_ce_prot: assert property (p_ce_prot) else $error("chip erase protected");

	property p_se_prot;
		@(posedge clk) disable iff (!rst_n)
		(erase_start && !erase_chip) |->
			!seepd_sect_prot($past(block_protect), erase_sector);
	endproperty
	a_se_prot: assert property (p_se_prot) else $error("sector protected");

	property p_busy_start;
		@(posedge clk) disable iff (!rst_n)
		erase_start |-> write_in_progress ##1 write_in_progress;
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy not set");

	property p_latch_needed;
		@(posedge clk) disable iff (!rst_n)
		erase_start |-> $past(write_enable_latch);
	endproperty
	a_latch_needed: assert property (p_latch_needed) else $error("no latch");

	property p_busy_clear;
		@(posedge clk) disable iff (!rst_n)
		$fell(write_in_progress) && !$past(ext_write_done) |->
			!write_enable_latch;
	endproperty
	a_busy_clear: assert property (p_busy_clear) else $error("latch kept");

	property p_dpd_quiet;
		@(posedge clk) disable iff (!rst_n)
		$past(st_r.dpd) |-> !erase_start && !$rose(write_enable_latch);
	endproperty
	a_dpd_quiet: assert property (p_dpd_quiet) else $error("cmd in dpd");

	property p_rel_time;
		@(posedge clk) disable iff (!rst_n)
		$fell(st_r.dpd) |-> st_r.rel [*8];
	endproperty
	a_rel_time: assert property (p_rel_time) else $error("release short");

	property p_miso_cs;
		@(posedge clk) disable iff (!rst_n)
		!miso_oe_n |-> st_r.phase == SEEPD_SIGOUT;
	endproperty
	a_miso_cs: assert property (p_miso_cs) else $error("miso stray");

	property p_inactive;
		@(posedge clk) disable iff (!rst_n)
		!active |-> miso_oe_n && !erase_start;
	endproperty
	a_inactive: assert property (p_inactive) else $error("acts early");

	property p_start_pulse;
		@(posedge clk) disable iff (!rst_n)
		erase_start |=> !erase_start;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("long start");

	property p_start_free;
		@(posedge clk) disable iff (!rst_n)
		erase_start |-> !$past(write_in_progress) && !$past(ext_write_busy);
	endproperty
	a_start_free: assert property (p_start_free) else $error("start busy");

	property p_busy_rise;
		@(posedge clk) disable iff (!rst_n)
		$rose(write_in_progress) |-> erase_start;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy stray");

	property p_busy_level;
		@(posedge clk) disable iff (!rst_n)
		write_in_progress && !t_done |-> t_busy;
	endproperty
	a_busy_level: assert property (p_busy_level) else $error("busy no timer");

	property p_dpd_rise;
		@(posedge clk) disable iff (!rst_n)
		$rose(st_r.dpd) |-> !$past(busy);
	endproperty
	a_dpd_rise: assert property (p_dpd_rise) else $error("dpd while busy");

	property p_rel_end;
		@(posedge clk) disable iff (!rst_n)
		$fell(st_r.rel) |-> !st_r.dpd;
	endproperty
	a_rel_end: assert property (p_rel_end) else $error("release stuck");

	property p_oe_busy;
		@(posedge clk) disable iff (!rst_n)
		!miso_oe_n |-> !write_in_progress;
	endproperty
	a_oe_busy: assert property (p_oe_busy) else $error("sig while busy");

	property p_ce_sector;
		@(posedge clk) disable iff (!rst_n)
		erase_start && erase_chip |-> erase_sector == 2'h0;
	endproperty
	a_ce_sector: assert property (p_ce_sector) else $error("chip sector");

	property p_act_stay;
		@(posedge clk) disable iff (!rst_n)
		active |=> active;
	endproperty
	a_act_stay: assert property (p_act_stay) else $error("active lost");

	property p_sig_first;
		@(posedge clk) disable iff (!rst_n)
		$fell(miso_oe_n) |-> miso == SEEPD_SIGNATURE[7];
	endproperty
	a_sig_first: assert property (p_sig_first) else $error("sig msb");

	c_se: cover property (@(posedge clk) erase_start && !erase_chip);
	c_ce: cover property (@(posedge clk) erase_start && erase_chip);
	c_dpd: cover property (@(posedge clk) $rose(st_r.dpd));
	c_sig: cover property (@(posedge clk) $fell(miso_oe_n));
endmodule : seepd_core

// [seepd_pkg.sv]
// seepd_pkg: shared constants and carrier types of the serial eeprom erase
// and deep power-down command block.
// assumes: one 10 MHz system clock; spi pins sampled from outside the domain.
// Function
// - sector erase fills addressed sector with FFh
// - sector erase: opcode plus three address bytes
// - cs rise after address starts erase
// - write in progress set during erase
// - protected sector erase aborts, memory unchanged
// - chip erase fills whole array with FFh
// - chip erase needs cs rise after eighth bit
// - chip erase ignored when any protect bit set
// - power-down entered only on cs rise
// - power-down ignores all but signature command
// - signature follows opcode and 24 dummy bits
// - signature repeats until cs rises
// - early cs rise still releases, after delay
// - signature served in standby unless busy
// - reset clears power-down, device in standby
// - write latch cleared on completed write
// - array accesses ignored while writing
// - power-on: standby, latch clear, output released
// - first falling cs edge activates device
// - write in progress reads one while busy (here it follows erase only, not ext_write_busy)
// - protect bits: none, quarter, half, all
package seepd_pkg;
	localparam logic [7:0] SEEPD_OP_WEN = 8'h06;
	localparam logic [7:0] SEEPD_OP_WRDI = 8'h04;
	localparam logic [7:0] SEEPD_OP_SE = 8'hD8;
	localparam logic [7:0] SEEPD_OP_CE = 8'hC7;
	localparam logic [7:0] SEEPD_OP_DPD = 8'hB9;
	localparam logic [7:0] SEEPD_OP_SIG = 8'hAB;
	// signature value is arbitrary
	localparam logic [7:0] SEEPD_SIGNATURE = 8'h5A;
	localparam int SEEPD_CLK_NS = 100;
	// erase time kept short so that a whole bench run stays brief
	localparam int SEEPD_ERASE_US = 500;
	localparam int SEEPD_REL_US = 100;
	localparam int SEEPD_ERASE_CYC = SEEPD_ERASE_US * 1000 / SEEPD_CLK_NS;
	localparam int SEEPD_REL_CYC = SEEPD_REL_US * 1000 / SEEPD_CLK_NS;
	localparam int SEEPD_SECT_LSB = 15;
	localparam int SEEPD_ADDR_W = 17;
	localparam logic [5:0] SEEPD_OP_BITS = 6'h08;
	localparam logic [5:0] SEEPD_ADR_BITS = 6'h20;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
	} seepd_pins_s;

	typedef struct packed {
		logic sclk_rise;
		logic sclk_fall;
		logic cs_fall;
		logic cs_rise;
		logic sel;
		logic mosi;
	} seepd_evt_s;

	typedef struct packed {
		logic start;
		logic chip;
		logic [1:0] sector;
	} seepd_erase_s;

	function automatic logic seepd_sect_prot(input logic [1:0] bp,
		input logic [1:0] sect);
		case (bp)
			2'h0: seepd_sect_prot = 1'b0;
			2'h1: seepd_sect_prot = (sect == 2'h3);
			2'h2: seepd_sect_prot = sect[1];
			default: seepd_sect_prot = 1'b1;
		endcase
	endfunction : seepd_sect_prot
endpackage : seepd_pkg

// [seepd_sync.sv]
// seepd_sync: two-stage synchroniser and edge finder for the spi pins.
// assumes: pins are asynchronous to clk.
`timescale 1ns/1ns
module seepd_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire seepd_pkg::seepd_pins_s pins,
	output seepd_pkg::seepd_evt_s evt
);
	import seepd_pkg::*;

	typedef struct packed {
		seepd_pins_s s1;
		seepd_pins_s s2;
		seepd_pins_s s3;
	} seepd_sync_state_s;

	seepd_sync_state_s st_r;
	seepd_sync_state_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pins;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{s1: 3'h2, s2: 3'h2, s3: 3'h2};
		end else begin
			st_r <= st_nxt;
		end
	end

	// edges are taken between stage two and three only
	assign evt.sclk_rise = st_r.s2.sclk & ~st_r.s3.sclk;
	assign evt.sclk_fall = ~st_r.s2.sclk & st_r.s3.sclk;
	assign evt.cs_fall = ~st_r.s2.cs_n & st_r.s3.cs_n;
	assign evt.cs_rise = st_r.s2.cs_n & ~st_r.s3.cs_n;
	assign evt.sel = ~st_r.s2.cs_n;
	assign evt.mosi = st_r.s2.mosi;
endmodule : seepd_sync

// [seepd_timer.sv]
// seepd_timer: loadable down counter for self-timed cycles.
// assumes: load wins over counting.
`timescale 1ns/1ns
module seepd_timer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [23:0] count,
	output logic busy,
	output logic done
);
	import seepd_pkg::*;

	typedef struct packed {
		logic [23:0] cnt;
		logic done;
	} seepd_timer_state_s;

	seepd_timer_state_s st_r;
	seepd_timer_state_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (load) begin
			st_nxt.cnt = count;
		end else if (st_r.cnt != 24'h000000) begin
			st_nxt.cnt = st_r.cnt - 24'h000001;
			st_nxt.done = (st_r.cnt == 24'h000001);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign busy = (st_r.cnt != 24'h000000);
	assign done = st_r.done;
endmodule : seepd_timer

// [seepd_host_model.sv]
// seepd_host_model: spi mode 0 host that frames commands for the block.
// assumes: tasks called from the bench; clk is the block's 10 MHz clock.
`timescale 1ns/1ns
module seepd_host_model (
	input wire logic clk,
	input wire logic miso,
	output logic sclk,
	output logic cs_n,
	output logic mosi
);
	// serial clock stands still low between frames
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b1;
	end

	// ****************************************
	// frame: n bits of tx msb first, 800 ns per bit
	// ****************************************
	task automatic xfer(input logic [47:0] tx, input int n,
		output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge clk);
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			mosi = tx[47 - i];
			repeat (5) @(negedge clk);
			rx = {rx[14:0], miso};
			sclk = 1'b1;
			repeat (3) @(negedge clk);
			sclk = 1'b0;
		end
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		// released data line must not keep its last value
		mosi = ~mosi;
		repeat (12) @(negedge clk);
	endtask : xfer
endmodule : seepd_host_model

// [testbench.sv]
// testbench: command sequences against the erase and power-down core.
// assumes: seepd_core as top, spi host model on its pins.
`timescale 1ns/1ns
`define CHK(name, exp, got) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) begin \
			failures++; \
			$display("ERROR %s expected %h seen %h", name, exp, got); \
		end \
	end
module testbench;
	import seepd_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic [1:0] block_protect = 2'h0;
	logic ext_write_busy = 1'b0;
	logic ext_write_done = 1'b0;
	logic miso, miso_oe_n, write_in_progress, write_enable_latch;
	logic deep_powerdown, active, erase_start, erase_chip;
	logic [1:0] erase_sector;
	logic [1:0] last_sect;
	logic [15:0] rx;
	logic last_chip;
	logic oe_seen = 1'b0;
	int failures = 0;
	int n_compared = 0;
	int n_start = 0;

	always #50 clk = ~clk;

	// ****************************************
	// monitors
	// ****************************************
	always @(posedge clk) begin
		if (erase_start === 1'b1) begin
			n_start++;
			last_chip = erase_chip;
			last_sect = erase_sector;
		end
		if (miso_oe_n === 1'b0)
			oe_seen = 1'b1;
	end

	seepd_core dut_u (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
		.mosi(mosi), .block_protect(block_protect),
		.ext_write_busy(ext_write_busy), .ext_write_done(ext_write_done),
		.miso(miso), .miso_oe_n(miso_oe_n),
		.write_in_progress(write_in_progress),
		.write_enable_latch(write_enable_latch),
		.deep_powerdown(deep_powerdown), .active(active),
		.erase_start(erase_start), .erase_chip(erase_chip),
		.erase_sector(erase_sector));

	seepd_host_model host_u (.clk(clk), .miso(miso), .sclk(sclk),
		.cs_n(cs_n), .mosi(mosi));

	task automatic cmd8(input logic [7:0] op);
		host_u.xfer({op, 40'h0}, 8, rx);
	endtask : cmd8

	task automatic test_done();
		if (failures == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		`CHK("oe_n", 1'b1, miso_oe_n);
		`CHK("latch", 1'b0, write_enable_latch);
		`CHK("active", 1'b0, active);
		cmd8(SEEPD_OP_WEN);
		`CHK("active", 1'b1, active);
		`CHK("latch", 1'b1, write_enable_latch);
		ext_write_done = 1'b1;
		@(negedge clk);
		ext_write_done = 1'b0;
		@(negedge clk);
		`CHK("latch", 1'b0, write_enable_latch);
		ext_write_busy = 1'b1;
		cmd8(SEEPD_OP_WEN);
		`CHK("latch", 1'b0, write_enable_latch);
		ext_write_busy = 1'b0;
		cmd8(SEEPD_OP_WEN);
		host_u.xfer({SEEPD_OP_SE, 24'h00ABCD, 16'h0}, 31, rx);
		cmd8(SEEPD_OP_WEN);
		block_protect = 2'h1;
		host_u.xfer({SEEPD_OP_SE, 24'h018000, 16'h0}, 32, rx);
		cmd8(SEEPD_OP_WEN);
		block_protect = 2'h2;
		cmd8(SEEPD_OP_CE);
		block_protect = 2'h0;
		cmd8(SEEPD_OP_WEN);
		host_u.xfer({SEEPD_OP_CE, 40'h0}, 9, rx);
		`CHK("starts", 0, n_start);
		host_u.xfer({SEEPD_OP_SIG, 40'h0}, 48, rx);
		`CHK("sig", {SEEPD_SIGNATURE, SEEPD_SIGNATURE}, rx);
		`CHK("oe_n", 1'b1, miso_oe_n);
		host_u.xfer({SEEPD_OP_DPD, 40'h0}, 9, rx);
		`CHK("dpd", 1'b0, deep_powerdown);
		cmd8(SEEPD_OP_WEN);
		cmd8(SEEPD_OP_DPD);
		`CHK("dpd", 1'b1, deep_powerdown);
		cmd8(SEEPD_OP_WRDI);
		`CHK("latch", 1'b1, write_enable_latch);
		cmd8(SEEPD_OP_SIG);
		`CHK("dpd", 1'b1, deep_powerdown);
		repeat (SEEPD_REL_CYC) @(negedge clk);
		`CHK("dpd", 1'b0, deep_powerdown);
		host_u.xfer({SEEPD_OP_SE, 24'h00ABCD, 16'h0}, 32, rx);
		`CHK("starts", 1, n_start);
		`CHK("chip", 1'b0, last_chip);
		`CHK("sector", 2'h1, last_sect);
		`CHK("busy", 1'b1, write_in_progress);
		oe_seen = 1'b0;
		host_u.xfer({SEEPD_OP_SIG, 40'h0}, 40, rx);
		`CHK("oe_seen", 1'b0, oe_seen);
		cmd8(SEEPD_OP_CE);
		`CHK("starts", 1, n_start);
		repeat (SEEPD_ERASE_CYC) @(negedge clk);
		`CHK("busy", 1'b0, write_in_progress);
		`CHK("latch", 1'b0, write_enable_latch);
		cmd8(SEEPD_OP_WEN);
		cmd8(SEEPD_OP_CE);
		`CHK("starts", 2, n_start);
		`CHK("chip", 1'b1, last_chip);
		rst_n = 1'b0;
		@(negedge clk);
		`CHK("busy", 1'b0, write_in_progress);
		rst_n = 1'b1;
		cmd8(SEEPD_OP_DPD);
		`CHK("dpd", 1'b1, deep_powerdown);
		rst_n = 1'b0;
		@(negedge clk);
		`CHK("dpd", 1'b0, deep_powerdown);
		`CHK("oe_n", 1'b1, miso_oe_n);
		rst_n = 1'b1;
		test_done();
	end

	// hang guard, about three times the expected run
	initial begin
		#3_000_000;
		failures++;
		test_done();
	end
endmodule : testbench
